//--- logic/pci_initiator_burst_write_stall.sv
// PCI initiator model with the write-burst tail-wait stall and recovery.
// Assumes on-chip requests and PCI target phase responses share clk_sys_i.
// Functional notes
// - Waits on last two write phases stall master
// - Reads and tail-without-wait bursts never stall
// - Stall only in master mode; target unaffected
// - Stalled master still buffers writes while room
// - Stalled: full-buffer writes and all reads retried
// - Bridge converts retries into split replies
// - Master reset bit clears stall, restores operation
// - Master reset discards every buffered access
`timescale 1ns/100ps
`default_nettype none
`include "pci_init_stall_regs.svh"
module pci_initiator_burst_write_stall
(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   // Control
   input  wire logic        mst_reset_i,
   // On-chip request port
   input  wire logic        req_valid_i,
   input  wire logic        req_write_i,
   input  wire logic [31:0] req_addr_i,
   input  wire logic [31:0] req_wdata_i,
   input  wire logic [3:0]  req_len_i,
   output logic             req_ready_o,
   output logic [1:0]       req_resp_o,
   // PCI master side, abstracted to phases
   output logic             pci_start_o,
   output logic             pci_write_o,
   output logic [31:0]      pci_addr_o,
   output logic [31:0]      pci_data_o,
   output logic             pci_last_o,
   input  wire logic        pci_trdy_i,
   input  wire logic        pci_wait_i,
   // Status
   output logic             stalled_o,
   output logic             target_active_o,
   input  wire logic        target_req_i
);
   localparam int DEPTH = `PIS_BUF_DEPTH;
   localparam int AW    = `PIS_BUF_AW;

   pci_init_stall_pkg::mst_state_e state_q;
   logic [31:0]   addr_mem_q [DEPTH];
   logic [31:0]   data_mem_q [DEPTH];
   logic          wr_mem_q   [DEPTH];
   logic [3:0]    len_mem_q  [DEPTH];
   logic [AW-1:0] wptr_q;
   logic [AW-1:0] rptr_q;
   logic [AW:0]   count_q;
   logic [3:0]    left_q;
   logic          full;
   logic          empty;
   logic          accept;
   logic          launch;
   logic          phase_done;
   logic          tail_waited;
   logic          stalled;
   logic          target_q;

   assign full       = (count_q == (AW+1)'(DEPTH));
   assign empty      = (count_q == '0);
   assign stalled    = (state_q == pci_init_stall_pkg::ST_STALL);
   assign phase_done = (state_q == pci_init_stall_pkg::ST_BURST) && pci_trdy_i;
   assign launch     = (state_q == pci_init_stall_pkg::ST_IDLE) && !empty
                       && !mst_reset_i;

   // Reads are retried while stalled; writes only once buffers are full
   assign accept = req_valid_i && !mst_reset_i && !full
                   && !(stalled && !req_write_i);
   assign req_ready_o = accept;

   always_comb
   begin
      req_resp_o = pci_init_stall_pkg::RESP_OKAY;
      // Upstream bridge turns RETRY into SPLIT for other masters
      if (req_valid_i && !accept)
         req_resp_o = pci_init_stall_pkg::RESP_RETRY;
   end

   // Request buffer; a master reset drops all queued accesses
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wptr_q  <= '0;
         rptr_q  <= '0;
         count_q <= '0;
      end
      else if (mst_reset_i)
      begin
         wptr_q  <= '0;
         rptr_q  <= '0;
         count_q <= '0;
      end
      else
      begin
         if (accept)
            wptr_q <= wptr_q + 1'b1;
         if (launch)
            rptr_q <= rptr_q + 1'b1;
         count_q <= count_q + (AW+1)'(accept) - (AW+1)'(launch);
      end
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_entry
         always_ff @(posedge clk_sys_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               addr_mem_q[g] <= '0;
               data_mem_q[g] <= '0;
               wr_mem_q[g]   <= 1'b0;
               len_mem_q[g]  <= '0;
            end
            else if (accept && wptr_q == AW'(g))
            begin
               addr_mem_q[g] <= req_addr_i;
               data_mem_q[g] <= req_wdata_i;
               wr_mem_q[g]   <= req_write_i;
               len_mem_q[g]  <= req_len_i;
            end
         end
      end
   endgenerate

   tail_wait_tracker u_tail
   (
      .clk_sys_i    (clk_sys_i),
      .rst_n_i      (rst_n_i),
      .start_i      (launch),
      .wait_i       ((state_q == pci_init_stall_pkg::ST_BURST) && pci_wait_i),
      .phase_done_i (phase_done),
      .tail_waited_o(tail_waited)
   );

   // Master sequencer; the lost last word leaves it stuck until reset
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q     <= pci_init_stall_pkg::ST_IDLE;
         left_q      <= '0;
         pci_start_o <= 1'b0;
         pci_write_o <= 1'b0;
         pci_addr_o  <= '0;
         pci_data_o  <= '0;
      end
      else
      begin
         pci_start_o <= 1'b0;
         if (mst_reset_i)
         begin
            state_q <= pci_init_stall_pkg::ST_IDLE;
            left_q  <= '0;
         end
         else
         begin
            case (state_q)
               pci_init_stall_pkg::ST_IDLE:
                  if (launch)
                  begin
                     state_q     <= pci_init_stall_pkg::ST_BURST;
                     left_q      <= len_mem_q[rptr_q];
                     pci_start_o <= 1'b1;
                     pci_write_o <= wr_mem_q[rptr_q];
                     pci_addr_o  <= addr_mem_q[rptr_q];
                     pci_data_o  <= data_mem_q[rptr_q];
                  end
               pci_init_stall_pkg::ST_BURST:
                  if (pci_trdy_i)
                  begin
                     if (left_q == '0)
                     begin
                        // Tail waits on a burst write lose the last word
                        if (pci_write_o && tail_waited)
                           state_q <= pci_init_stall_pkg::ST_STALL;
                        else
                           state_q <= pci_init_stall_pkg::ST_IDLE;
                     end
                     else
                        left_q <= left_q - 4'h1;
                  end
               pci_init_stall_pkg::ST_STALL:
                  state_q <= pci_init_stall_pkg::ST_STALL;
               default:
                  state_q <= pci_init_stall_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // Burst length counts extra phases; tail check uses the recorded history
   assign pci_last_o = (state_q == pci_init_stall_pkg::ST_BURST) && (left_q == '0);
   assign stalled_o  = stalled;

   // Target path stays independent of the master stall
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         target_q <= 1'b0;
      else
         target_q <= target_req_i;
   end
   assign target_active_o = target_q;

   a_read_no_stall: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (phase_done && !pci_write_o) |=> !stalled)
      else $error("read burst caused stall");
   a_stall_from_burst: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (!$past(stalled) && stalled) |-> $past(pci_write_o && pci_last_o && tail_waited))
      else $error("stall without tail-wait write");
   a_stall_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (stalled && !mst_reset_i) |=> stalled)
      else $error("stall left without reset");
   a_read_retry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (stalled && req_valid_i && !req_write_i) |->
         req_resp_o == pci_init_stall_pkg::RESP_RETRY)
      else $error("read not retried in stall");
   a_write_buffer: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (stalled && req_valid_i && req_write_i && !full && !mst_reset_i) |-> req_ready_o)
      else $error("write refused with room");
   a_reset_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      mst_reset_i |=> (state_q == pci_init_stall_pkg::ST_IDLE) && empty)
      else $error("master reset did not clear");
   a_reset_no_launch: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      mst_reset_i |=> !pci_start_o)
      else $error("discarded access launched");
   a_target_free: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      target_req_i |=> target_active_o)
      else $error("target path blocked");
endmodule
`default_nettype wire

//--- logic/pci_init_stall_regs.svh
// Constants for the PCI initiator write-burst stall model.
// Assumes inclusion by the design files and the bench.
`ifndef PCI_INIT_STALL_REGS_SVH
`define PCI_INIT_STALL_REGS_SVH
`define PIS_BUF_DEPTH     4
`define PIS_BUF_AW        2
`define PIS_TAIL_PHASES   2
`endif

//--- logic/pci_init_stall_pkg.sv
// Types for the PCI initiator write-burst stall model.
// Assumes nothing beyond a SystemVerilog compiler.
package pci_init_stall_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_BURST,
      ST_STALL
   } mst_state_e;
   typedef enum logic [1:0] {
      RESP_OKAY,
      RESP_ERROR,
      RESP_RETRY,
      RESP_SPLIT
   } ahb_resp_e;
endpackage

//--- logic/tail_wait_tracker.sv
// Tracks wait states on the last data phases of a PCI write burst.
// Assumes phase strobes are synchronous to clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
`include "pci_init_stall_regs.svh"
module tail_wait_tracker
(
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   // Burst phase events
   input  wire logic start_i,
   input  wire logic wait_i,
   input  wire logic phase_done_i,
   // Result
   output logic      tail_waited_o
);
   logic [`PIS_TAIL_PHASES-2:0] hist_q;
   logic                        cur_wait_q;

   // Each finished phase records whether it waited; the earlier N-1 are kept
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         hist_q     <= '0;
         cur_wait_q <= 1'b0;
      end
      else if (start_i)
      begin
         hist_q     <= '0;
         cur_wait_q <= 1'b0;
      end
      else if (phase_done_i)
      begin
         hist_q     <= (`PIS_TAIL_PHASES-1)'({hist_q, cur_wait_q});
         cur_wait_q <= 1'b0;
      end
      else if (wait_i)
      begin
         cur_wait_q <= 1'b1;
      end
   end

   // The finishing phase's own wait is still in cur_wait_q at its done strobe
   assign tail_waited_o = &{hist_q, cur_wait_q};
endmodule
`default_nettype wire

//--- tb/pci_target_model.sv
// PCI target model: answers data phases, one wait cycle where masked.
// Assumes the bench holds phase count and mask steady during a burst.
`timescale 1ns/100ps
`default_nettype none
module pci_target_model
(
   // Clock
   input  wire logic        clk_sys_i,
   // Burst control
   input  wire logic        start_i,
   input  wire logic [4:0]  phases_i,
   input  wire logic [15:0] wait_mask_i,
   // Phase answers
   output logic             trdy_o,
   output logic             wait_o,
   output logic             busy_o
);
   int ph;
   bit waited;
   initial
   begin
      trdy_o = 1'b0;
      wait_o = 1'b0;
      busy_o = 1'b0;
   end
   // Counts phases itself, so a master that loses its last word cannot hang it
   always @(negedge clk_sys_i)
   begin
      trdy_o <= 1'b0;
      wait_o <= 1'b0;
      if (start_i)
      begin
         busy_o <= 1'b1;
         ph = 0;
         waited = 1'b0;
      end
      else if (busy_o)
      begin
         if (wait_mask_i[ph] && !waited)
         begin
            wait_o <= 1'b1;
            waited = 1'b1;
         end
         else
         begin
            trdy_o <= 1'b1;
            waited = 1'b0;
            ph++;
            if (ph == int'(phases_i))
               busy_o <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/pci_initiator_burst_write_stall_bench.sv
// Bench: drives bursts with chosen wait patterns and checks stall and recovery.
// Assumes the target model answers all phases on the system clock.
`timescale 1ns/100ps
`default_nettype none
`include "pci_init_stall_regs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
   $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module pci_initiator_burst_write_stall_bench;
   logic        clk_sys_i, rst_n_i, mst_reset_i, req_valid_i, req_write_i;
   logic [31:0] req_addr_i, req_wdata_i, pci_addr_o, pci_data_o, rng;
   logic [3:0]  req_len_i;
   logic [1:0]  req_resp_o;
   logic        req_ready_o, pci_start_o, pci_write_o, pci_last_o, pci_trdy_i;
   logic        pci_wait_i, stalled_o, target_active_o, target_req_i, busy;
   logic [4:0]  phases;
   logic [15:0] wmask;
   logic [64:0] exp_q[$];
   int          failures, checks_done, cycles, lastc;
   pci_initiator_burst_write_stall i_pci_initiator_burst_write_stall (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .mst_reset_i(mst_reset_i), .req_valid_i(req_valid_i),
      .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .req_len_i(req_len_i), .req_ready_o(req_ready_o), .req_resp_o(req_resp_o),
      .pci_start_o(pci_start_o), .pci_write_o(pci_write_o), .pci_addr_o(pci_addr_o),
      .pci_data_o(pci_data_o), .pci_last_o(pci_last_o), .pci_trdy_i(pci_trdy_i),
      .pci_wait_i(pci_wait_i), .stalled_o(stalled_o), .target_active_o(target_active_o),
      .target_req_i(target_req_i));
   pci_target_model i_pci_target_model (.clk_sys_i(clk_sys_i), .start_i(pci_start_o),
      .phases_i(phases), .wait_mask_i(wmask), .trdy_o(pci_trdy_i), .wait_o(pci_wait_i),
      .busy_o(busy));
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   task automatic stop_test();
      if (failures == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic send(input logic w, input logic [3:0] len, output logic ok,
                       output logic [1:0] rs);
      @(negedge clk_sys_i);
      req_valid_i = 1'b1;
      req_write_i = w;
      req_len_i = len;
      req_addr_i = xs();
      req_wdata_i = xs();
      #1;
      ok = req_ready_o;
      rs = req_resp_o;
      @(negedge clk_sys_i);
      req_valid_i = 1'b0;
   endtask
   task automatic recover();
      logic ok;
      logic [1:0] rs;
      int n;
      n = 0;
      for (int i = 0; i < 8; i++)
      begin
         send(1'b1, 4'h0, ok, rs);
         if (ok === 1'b1)
            n++;
      end
      `CHK(n, `PIS_BUF_DEPTH)
      `CHK(rs, pci_init_stall_pkg::RESP_RETRY)
      send(1'b0, 4'h0, ok, rs);
      `CHK({ok, rs}, {1'b0, pci_init_stall_pkg::RESP_RETRY})
      @(negedge clk_sys_i);
      mst_reset_i = 1'b1;
      @(negedge clk_sys_i);
      mst_reset_i = 1'b0;
      `CHK(stalled_o, 1'b0)
      n = 0;
      repeat (10)
      begin
         @(negedge clk_sys_i);
         if (pci_start_o === 1'b1)
            n++;
      end
      `CHK(n, 0)
   endtask
   task automatic burst(input logic w, input logic [3:0] len, input logic [15:0] m);
      logic ok;
      logic [1:0] rs;
      logic st;
      phases = {1'b0, len} + 5'h01;
      wmask = m;
      lastc = 0;
      st = w && len != 4'h0 && m[len] && m[len - 4'h1];
      send(w, len, ok, rs);
      `CHK(ok, 1'b1)
      exp_q.push_back({w, req_addr_i, req_wdata_i});
      for (int i = 0; i < 10 && !busy; i++)
         @(negedge clk_sys_i);
      for (int i = 0; i < 100 && busy; i++)
         @(negedge clk_sys_i);
      repeat (3) @(negedge clk_sys_i);
      `CHK({pci_write_o, pci_addr_o, pci_data_o}, exp_q.pop_front())
      `CHK(stalled_o, st)
      `CHK(lastc, (len == 4'h0 ? 2 : 1) + int'(m[len]))
      if (st)
         recover();
   endtask
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         stop_test();
      end
   end
   // Final-phase marker stands from its phase start until that phase's trdy
   always @(negedge clk_sys_i)
      if (pci_last_o === 1'b1)
         lastc++;
   // Target side keeps mirroring its request, stalled or not
   always @(negedge clk_sys_i)
   begin
      if (cycles > 9)
         `CHK(target_active_o, target_req_i)
      target_req_i <= xs() > 32'h7fffffff;
   end
   initial
   begin
      rng = 32'h00000045;
      {rst_n_i, mst_reset_i, req_valid_i, req_write_i, target_req_i} = 5'h00;
      {req_addr_i, req_wdata_i, req_len_i, phases, wmask} = '0;
      repeat (8) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      burst(1'b1, 4'h3, 16'h000f);
      burst(1'b1, 4'h3, 16'h0008);
      burst(1'b1, 4'h3, 16'h0004);
      burst(1'b0, 4'h3, 16'h000f);
      burst(1'b1, 4'h0, 16'h0001);
      burst(1'b1, 4'h1, 16'h0003);
      burst(1'b1, 4'hf, 16'h0000);
      repeat (8)
         burst(rng[3], rng[7:4], 16'(xs()));
      stop_test();
   end
endmodule
`default_nettype wire
